// ### rcl_consts.svh
`ifndef RCL_CONSTS_SVH
`define RCL_CONSTS_SVH

// APB register byte offsets
`define RCL_OFS_STATUS 8'h00
`define RCL_OFS_WDCTL 8'h04
`define RCL_OFS_OPTION 8'h08
`define RCL_OFS_CMD 8'h0C
`define RCL_OFS_IRQ_STAT 8'h10
`define RCL_OFS_IRQ_CLR 8'h14
`define RCL_OFS_IRQ_EN 8'h18

// Status register fields
`define RCL_ST_DONE 0
`define RCL_ST_RESTORE 1
`define RCL_ST_CMDBUSY 2
`define RCL_ST_SECURED 3

// Interrupt event bits
`define RCL_EV_RESTORED 0
`define RCL_EV_CMDDONE 1
`define RCL_EV_REJECT 2
`define RCL_EV_W 3

// Option byte location and restore partition
`define RCL_OPT_ADDR 23'h7FFF0E
`define RCL_PART_BASE 23'h100000
`define RCL_PART_WORDS 16
`define RCL_PART_AW 4

// Cycles after reset before the synchronised security level is trusted
`define RCL_SEC_SETTLE 4

// Watchdog field reset values and secured override
`define RCL_RATE_RST 3'h0
`define RCL_RATE_LONGEST 3'h7

// Flash command duration
`define RCL_CMD_TIME_NS 2000
`define RCL_CLK_NS 10
`define RCL_CMD_CYCLES (`RCL_CMD_TIME_NS / `RCL_CLK_NS)

`endif

// ### rcl_pkg.sv
package rcl_pkg;

  // Start-up and command sequencer states
  typedef enum logic [2:0] {
    OPT_REQ,
    OPT_WAIT,
    PART_REQ,
    PART_WAIT,
    READY,
    CMD_RUN
  } rcl_state_t;

endpackage

// ### rcl_reset_config_loader.sv
// Our own choices: the APB slave port and the register addresses.
`include "rcl_consts.svh"

// Contract
// - Restore emulated eeprom, then set completion flag
// - Stall processor RAM access until flag set
// - After flag, no stall; accept flash commands
// - Reset aborts any running flash command immediately
// - RAM arrays not cleared by reset
// - At reset release load watchdog rate, window bits
// - Fill option register from configuration byte
// - Secured device forces longest watchdog rate
// - Rate equals inverted option bits two..zero
// - Window mode equals inverted option bit three
module rcl_reset_config_loader (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Data flash read port
  output logic dfReq,
  output logic [22:0] dfAddr,
  input wire logic [15:0] dfRdata,
  input wire logic dfValid,
  // Processor access to emulated eeprom RAM
  input wire logic cpuReq,
  input wire logic cpuWe,
  input wire logic [3:0] cpuAddr,
  input wire logic [15:0] cpuWdata,
  output logic [15:0] cpuRdata,
  output logic cpuAck,
  // Security pin and results
  input wire logic securedPin,
  output logic [2:0] watchdogRate,
  output logic watchdogWindowMode,
  output logic flashBusy,
  output logic irq
);

  // Security pin synchroniser stages
  logic secS1_ff, secS2_ff, secS3_ff, secured_ff;
  logic nxt_secS1, nxt_secS2, nxt_secS3, nxt_secured;

  // Sequencer state and counters
  rcl_pkg::rcl_state_t state_ff, nxt_state;
  logic [`RCL_PART_AW-1:0] idx_ff, nxt_idx;
  logic [15:0] cmdCnt_ff, nxt_cmdCnt;
  logic doneFlag_ff, nxt_doneFlag;
  logic [7:0] option_ff, nxt_option;
  logic [2:0] rate_ff, nxt_rate;
  logic window_ff, nxt_window;
  logic dfReq_ff, nxt_dfReq;
  logic [22:0] dfAddr_ff, nxt_dfAddr;
  logic busy_ff, nxt_busy;

  // Processor port
  logic [15:0] cpuRdata_ff, nxt_cpuRdata;
  logic cpuAck_ff, nxt_cpuAck;

  // Interrupt registers
  logic [`RCL_EV_W-1:0] irqStat_ff, nxt_irqStat;
  logic [`RCL_EV_W-1:0] irqEn_ff, nxt_irqEn;
  logic irq_ff, nxt_irq;
  logic [`RCL_EV_W-1:0] events;

  // APB answer registers
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready;
  logic pslverr_ff, nxt_pslverr;

  // Emulated eeprom RAM; no reset on purpose
  logic [15:0] emuRam [0:`RCL_PART_WORDS-1];
  logic ramWe;
  logic [`RCL_PART_AW-1:0] ramAddr;
  logic [15:0] ramWdata;

  // Access phase strobes
  logic apbAccess, apbWrite, cmdWrite;

  assign apbAccess = psel & penable & ~pready_ff;
  assign apbWrite = apbAccess & pwrite;
  assign cmdWrite = apbWrite & (paddr == `RCL_OFS_CMD);

  // Security pin: three stages, change taken when two and three agree
  always_comb begin
    nxt_secS1 = securedPin;
    nxt_secS2 = secS1_ff;
    nxt_secS3 = secS2_ff;
    nxt_secured = secured_ff;
    if (secS2_ff == secS3_ff) begin
      nxt_secured = secS3_ff;
    end
  end

  // Synchroniser registers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      secS1_ff <= 1'b0;
      secS2_ff <= 1'b0;
      secS3_ff <= 1'b0;
      secured_ff <= 1'b0;
    end else begin
      secS1_ff <= nxt_secS1;
      secS2_ff <= nxt_secS2;
      secS3_ff <= nxt_secS3;
      secured_ff <= nxt_secured;
    end
  end

  // Sequencer: option fetch, RAM restore, then command service
  always_comb begin
    nxt_state = state_ff;
    nxt_idx = idx_ff;
    nxt_cmdCnt = cmdCnt_ff;
    nxt_doneFlag = doneFlag_ff;
    nxt_option = option_ff;
    nxt_rate = rate_ff;
    nxt_window = window_ff;
    nxt_dfReq = 1'b0;
    nxt_dfAddr = dfAddr_ff;
    nxt_busy = busy_ff;
    events = '0;
    ramWe = 1'b0;
    ramAddr = cpuAddr;
    ramWdata = cpuWdata;
    case (state_ff)
      // Ask for the configuration byte
      rcl_pkg::OPT_REQ: begin
        // Wait until the security level has crossed the synchroniser,
        // else a secured part would load the option-derived rate
        if (idx_ff == `RCL_PART_AW'(`RCL_SEC_SETTLE)) begin
          nxt_dfReq = 1'b1;
          nxt_dfAddr = `RCL_OPT_ADDR;
          nxt_state = rcl_pkg::OPT_WAIT;
        end else begin
          nxt_idx = idx_ff + `RCL_PART_AW'(1);
        end
      end
      // Capture option byte and derive watchdog settings
      rcl_pkg::OPT_WAIT: begin
        if (dfValid) begin
          nxt_option = dfRdata[7:0];
          nxt_window = ~dfRdata[3];
          if (secured_ff) begin
            // Security wins over the option bits
            nxt_rate = `RCL_RATE_LONGEST;
          end else begin
            nxt_rate = ~dfRdata[2:0];
          end
          nxt_idx = '0;
          nxt_state = rcl_pkg::PART_REQ;
        end
      end
      // Read next partition word
      rcl_pkg::PART_REQ: begin
        nxt_dfReq = 1'b1;
        nxt_dfAddr = `RCL_PART_BASE + {19'h00000, idx_ff};
        nxt_state = rcl_pkg::PART_WAIT;
      end
      // Store word into RAM; finish sets completion flag
      rcl_pkg::PART_WAIT: begin
        if (dfValid) begin
          ramWe = 1'b1;
          ramAddr = idx_ff;
          ramWdata = dfRdata;
          if (idx_ff == `RCL_PART_AW'(`RCL_PART_WORDS - 1)) begin
            nxt_doneFlag = 1'b1;
            events[`RCL_EV_RESTORED] = 1'b1;
            nxt_state = rcl_pkg::READY;
          end else begin
            nxt_idx = idx_ff + `RCL_PART_AW'(1);
            nxt_state = rcl_pkg::PART_REQ;
          end
        end
      end
      // Idle: processor owns RAM, commands accepted
      rcl_pkg::READY: begin
        if (cpuReq && cpuWe && !cpuAck_ff) begin
          ramWe = 1'b1;
        end
        if (cmdWrite) begin
          nxt_doneFlag = 1'b0;
          nxt_busy = 1'b1;
          nxt_cmdCnt = 16'(`RCL_CMD_CYCLES - 1);
          nxt_state = rcl_pkg::CMD_RUN;
        end
      end
      // Command running; only reset can cut it short
      rcl_pkg::CMD_RUN: begin
        if (cpuReq && cpuWe && !cpuAck_ff) begin
          ramWe = 1'b1;
        end
        if (cmdCnt_ff == 16'h0000) begin
          nxt_busy = 1'b0;
          nxt_doneFlag = 1'b1;
          events[`RCL_EV_CMDDONE] = 1'b1;
          nxt_state = rcl_pkg::READY;
        end else begin
          nxt_cmdCnt = cmdCnt_ff - 16'h0001;
        end
      end
      default: begin
        nxt_state = rcl_pkg::OPT_REQ;
      end
    endcase
    // A command written while the flag is low is refused
    if (cmdWrite && !doneFlag_ff) begin
      events[`RCL_EV_REJECT] = 1'b1;
    end
  end

  // Sequencer registers; reset kills a running command at once
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_ff <= rcl_pkg::OPT_REQ;
      idx_ff <= '0;
      cmdCnt_ff <= 16'h0000;
      doneFlag_ff <= 1'b0;
      option_ff <= 8'hFF;
      rate_ff <= `RCL_RATE_RST;
      window_ff <= 1'b0;
      dfReq_ff <= 1'b0;
      dfAddr_ff <= 23'h000000;
      busy_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      idx_ff <= nxt_idx;
      cmdCnt_ff <= nxt_cmdCnt;
      doneFlag_ff <= nxt_doneFlag;
      option_ff <= nxt_option;
      rate_ff <= nxt_rate;
      window_ff <= nxt_window;
      dfReq_ff <= nxt_dfReq;
      dfAddr_ff <= nxt_dfAddr;
      busy_ff <= nxt_busy;
    end
  end

  // RAM write port; contents survive or float across reset
  always_ff @(posedge clock) begin
    if (ramWe) begin
      emuRam[ramAddr] <= ramWdata;
    end
  end

  // Processor port: ack withheld until the flag is set
  always_comb begin
    nxt_cpuAck = 1'b0;
    nxt_cpuRdata = cpuRdata_ff;
    if (cpuReq && doneFlag_ff && !cpuAck_ff) begin
      nxt_cpuAck = 1'b1;
      nxt_cpuRdata = emuRam[cpuAddr];
    end
  end

  // Processor port registers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cpuAck_ff <= 1'b0;
      cpuRdata_ff <= 16'h0000;
    end else begin
      cpuAck_ff <= nxt_cpuAck;
      cpuRdata_ff <= nxt_cpuRdata;
    end
  end

  // Sticky events; a new event beats a clear in the same cycle
  always_comb begin
    nxt_irqStat = irqStat_ff;
    nxt_irqEn = irqEn_ff;
    if (apbWrite && paddr == `RCL_OFS_IRQ_CLR) begin
      nxt_irqStat = irqStat_ff & ~pwdata[`RCL_EV_W-1:0];
    end
    if (apbWrite && paddr == `RCL_OFS_IRQ_EN) begin
      nxt_irqEn = pwdata[`RCL_EV_W-1:0];
    end
    nxt_irqStat = nxt_irqStat | events;
    nxt_irq = |(nxt_irqStat & nxt_irqEn);
  end

  // Interrupt registers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      irqStat_ff <= '0;
      irqEn_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      irqStat_ff <= nxt_irqStat;
      irqEn_ff <= nxt_irqEn;
      irq_ff <= nxt_irq;
    end
  end

  // APB: one wait state, answer registered; unmapped gets error
  always_comb begin
    nxt_pready = 1'b0;
    nxt_pslverr = 1'b0;
    nxt_prdata = 32'h00000000;
    if (apbAccess) begin
      nxt_pready = 1'b1;
      case (paddr)
        // Live flag and activity
        `RCL_OFS_STATUS: begin
          nxt_prdata[`RCL_ST_DONE] = doneFlag_ff;
          nxt_prdata[`RCL_ST_RESTORE] = ~doneFlag_ff & ~busy_ff;
          nxt_prdata[`RCL_ST_CMDBUSY] = busy_ff;
          nxt_prdata[`RCL_ST_SECURED] = secured_ff;
        end
        // Loaded watchdog settings
        `RCL_OFS_WDCTL: begin
          nxt_prdata[2:0] = rate_ff;
          nxt_prdata[3] = window_ff;
        end
        // Option byte copy
        `RCL_OFS_OPTION: begin
          nxt_prdata[7:0] = option_ff;
        end
        // Write-only registers read as zero
        `RCL_OFS_CMD, `RCL_OFS_IRQ_CLR: begin
          nxt_prdata = 32'h00000000;
        end
        `RCL_OFS_IRQ_STAT: begin
          nxt_prdata[`RCL_EV_W-1:0] = irqStat_ff;
        end
        `RCL_OFS_IRQ_EN: begin
          nxt_prdata[`RCL_EV_W-1:0] = irqEn_ff;
        end
        default: begin
          nxt_pslverr = 1'b1;
        end
      endcase
      if (pwrite) begin
        nxt_prdata = 32'h00000000;
      end
    end
  end

  // APB answer registers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      prdata_ff <= 32'h00000000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // Outputs straight from flops
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign dfReq = dfReq_ff;
  assign dfAddr = dfAddr_ff;
  assign cpuRdata = cpuRdata_ff;
  assign cpuAck = cpuAck_ff;
  assign watchdogRate = rate_ff;
  assign watchdogWindowMode = window_ff;
  assign flashBusy = busy_ff;
  assign irq = irq_ff;

endmodule

// ### rcl_checker_props.sv
module rcl_checker (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Register bus handshake
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  // Data flash port
  input wire logic dfReq,
  input wire logic [22:0] dfAddr,
  input wire logic [15:0] dfRdata,
  input wire logic dfValid,
  // Processor port and results
  input wire logic cpuReq,
  input wire logic cpuAck,
  input wire logic securedPin,
  input wire logic [2:0] watchdogRate,
  input wire logic watchdogWindowMode,
  input wire logic flashBusy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  logic pend_ff, nxt_pend; // Flash read outstanding
  logic [4:0] cnt_ff, nxt_cnt; // Flash answers since reset, stops at 17
  logic [8:0] busyCnt_ff, nxt_busyCnt; // Cycles the command has run

  // Next values of the tracking state
  always_comb begin
    nxt_pend = dfReq | (pend_ff & ~dfValid);
    nxt_cnt = cnt_ff + 5'(pend_ff & dfValid & (cnt_ff != 5'h11));
    nxt_busyCnt = flashBusy ? busyCnt_ff + 9'h001 : 9'h000;
  end

  // Registers; reset restarts the count of answers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pend_ff <= 1'h0;
      cnt_ff <= 5'h00;
      busyCnt_ff <= 9'h000;
    end else begin
      pend_ff <= nxt_pend;
      cnt_ff <= nxt_cnt;
      busyCnt_ff <= nxt_busyCnt;
    end
  end

  a_option_read_first: assert property ($rose(resetn) |-> ##5
    (dfReq && dfAddr == 23'h7FFF0E)) else $error("no option read");
  a_rate_inverted: assert property (pend_ff && cnt_ff == 5'h00 &&
    dfValid && !securedPin |=> watchdogRate == ~$past(dfRdata[2:0]))
    else $error("rate not inverted option");
  a_secure_longest: assert property (pend_ff && cnt_ff == 5'h00 &&
    dfValid && securedPin |=> watchdogRate == 3'h7)
    else $error("secured rate not longest");
  a_window_inverted: assert property (pend_ff && cnt_ff == 5'h00 &&
    dfValid |=> watchdogWindowMode == !$past(dfRdata[3]))
    else $error("window bit not inverted");
  a_stall_early: assert property (cnt_ff != 5'h11 |-> !cpuAck)
    else $error("ack before restore");
  a_ack_ready: assert property (cnt_ff == 5'h11 &&
    $past(cnt_ff) == 5'h11 && cpuReq && !cpuAck && !flashBusy |=> cpuAck)
    else $error("ack missing");
  a_cmd_length: assert property ($fell(flashBusy) |->
    busyCnt_ff == 9'h0C8) else $error("command length");
  a_reset_abort: assert property ($rose(resetn) |-> !flashBusy)
    else $error("command survived reset");
  a_apb_wait: assert property (psel && penable && !pready |=> pready)
    else $error("no bus answer");
  c_ack: cover property (cpuAck);
  c_cmd_end: cover property ($fell(flashBusy));
  c_bus_done: cover property (psel && penable && pready);
endmodule

bind rcl_reset_config_loader rcl_checker u_chk (.clock(clock),
  .resetn(resetn), .psel(psel), .penable(penable), .pready(pready),
  .dfReq(dfReq), .dfAddr(dfAddr), .dfRdata(dfRdata), .dfValid(dfValid),
  .cpuReq(cpuReq), .cpuAck(cpuAck), .securedPin(securedPin),
  .watchdogRate(watchdogRate), .watchdogWindowMode(watchdogWindowMode),
  .flashBusy(flashBusy));

// ### testbench.sv
`include "rcl_consts.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // Design inputs, all given a value at time zero
  logic clock = 1'h0, resetn = 1'h0, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, dfValid = 1'h0, cpuReq = 1'h0, cpuWe = 1'h0;
  logic securedPin = 1'h0;
  logic [7:0] paddr = 8'h00, opt = 8'h00;
  logic [31:0] wd = 32'h0; // Write data for register writes
  logic [16:0] cq; // Oldest processor note, monitor only
  logic [31:0] pwdata = 32'h0, prdata, seed = 32'h00017D05, r;
  logic [15:0] dfRdata = 16'h0, cpuWdata = 16'h0, cpuRdata;
  logic [3:0] cpuAddr = 4'h0;
  // Design outputs
  logic pready, pslverr, dfReq, cpuAck, flashBusy, irq, watchdogWindowMode;
  logic [22:0] dfAddr, fa;
  logic [2:0] watchdogRate;
  logic [15:0] img [16]; // Contents of the restore partition
  logic [32:0] apbQ [$]; // Expected {error, read data}
  logic [16:0] cpuQ [$]; // Expected {ignore, read data}
  int n_errors = 0, n_tests = 0, i;

  rcl_reset_config_loader DUT (.clock(clock), .resetn(resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dfReq(dfReq), .dfAddr(dfAddr), .dfRdata(dfRdata), .dfValid(dfValid),
    .cpuReq(cpuReq), .cpuWe(cpuWe), .cpuAddr(cpuAddr), .cpuWdata(cpuWdata),
    .cpuRdata(cpuRdata), .cpuAck(cpuAck), .securedPin(securedPin),
    .watchdogRate(watchdogRate), .watchdogWindowMode(watchdogWindowMode),
    .flashBusy(flashBusy), .irq(irq));

  always #5 clock = ~clock;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task chk(input logic [32:0] seen, input logic [32:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h want %h", $time, seen, exp);
    end
  endtask

  // One bus transfer; the result is noted for the monitor
  task apb(input logic w, input logic [7:0] a, input logic [32:0] e);
    apbQ.push_back(e);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= w ? wd : rnd();
    @(posedge clock);
    penable <= 1'h1;
    do @(posedge clock); while (pready !== 1'h1);
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clock);
  endtask

  // One processor access, held until acknowledged
  task cpu(input logic w, input logic [3:0] a, input logic [16:0] e);
    cpuQ.push_back(e);
    cpuReq <= 1'h1;
    cpuWe <= w;
    cpuAddr <= a;
    cpuWdata <= e[15:0];
    do @(posedge clock); while (cpuAck !== 1'h1);
    cpuReq <= 1'h0;
    @(posedge clock);
  endtask

  // Reset, then a stalled read during restore and the loaded settings
  task boot(input logic [7:0] o, input logic s);
    resetn <= 1'h0;
    opt <= o;
    securedPin <= s;
    repeat (20) @(posedge clock);
    chk(flashBusy, 1'h0);
    resetn <= 1'h1;
    cpu(1'h0, o[3:0], {1'h0, img[o[3:0]]});
    apb(1'h0, `RCL_OFS_STATUS, {29'h0, s, 3'h1});
    apb(1'h0, `RCL_OFS_WDCTL, {29'h0, ~o[3], s ? 3'h7 : ~o[2:0]});
    apb(1'h0, `RCL_OFS_OPTION, {25'h0, o});
  endtask

  // Monitor: every answer is compared with the oldest note, except processor answers whose note is marked ignore
  always @(posedge clock) begin
    if (pready === 1'h1) chk({pslverr, prdata}, apbQ.pop_front());
    if (cpuAck === 1'h1) begin
      cq = cpuQ.pop_front();
      if (!cq[16]) chk(cpuRdata, cq[15:0]);
    end
  end

  // Data flash stand-in: answers after a random delay
  initial forever begin
    @(posedge clock);
    if (dfReq === 1'h1) begin
      fa = dfAddr;
      repeat (rnd() % 4) @(posedge clock);
      dfValid <= 1'h1;
      dfRdata <= (fa == `RCL_OPT_ADDR) ? {8'(rnd()), opt} : img[fa[3:0]];
      @(posedge clock);
      dfValid <= 1'h0;
      dfRdata <= ~dfRdata; // Released lines do not keep the old value
    end
  end

  task conclude();
    $display("n_errors %0d n_tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    #300000;
    n_errors++;
    conclude();
  end

  initial begin
    for (i = 0; i < 16; i++) img[i] = 16'(rnd());
    // Every rate code, both window codes, last pass secured
    for (i = 0; i < 9; i++) begin
      r = rnd();
      boot({r[7:4], i[1] ^ i[0], i[2:0] ^ {3{i[3]}}}, i[3]);
    end
    wd = 32'h7; // Enable all events, later clear all
    apb(1'h1, `RCL_OFS_IRQ_EN, 33'h0);
    apb(1'h1, `RCL_OFS_CMD, 33'h0);
    apb(1'h0, `RCL_OFS_STATUS, 33'hC);
    apb(1'h1, `RCL_OFS_CMD, 33'h0);
    while (flashBusy === 1'h1) @(posedge clock);
    apb(1'h0, `RCL_OFS_IRQ_STAT, 33'h7);
    chk(irq, 1'h1);
    apb(1'h1, `RCL_OFS_IRQ_CLR, 33'h0);
    apb(1'h0, `RCL_OFS_IRQ_STAT, 33'h0);
    chk(irq, 1'h0);
    apb(1'h0, 8'h20, {1'h1, 32'h0});
    apb(1'h0, `RCL_OFS_IRQ_EN, 33'h7);
    r = rnd();
    cpu(1'h1, 4'h5, {1'h1, r[15:0]});
    cpu(1'h0, 4'h5, {1'h0, r[15:0]});
    apb(1'h1, `RCL_OFS_CMD, 33'h0);
    repeat (5) @(posedge clock);
    boot(8'h3A, 1'h0);
    conclude();
  end
endmodule
